/* common/carkit_pkg.sv */
package carkit_pkg;

	// ***************************************************
	// register addresses
	// ***************************************************
	localparam logic [5:0] CTRL_WR   = 6'h19;
	localparam logic [5:0] CTRL_SET  = 6'h1a;
	localparam logic [5:0] CTRL_CLR  = 6'h1b;
	localparam logic [5:0] IEN_WR    = 6'h1d;
	localparam logic [5:0] IEN_SET   = 6'h1e;
	localparam logic [5:0] IEN_CLR   = 6'h1f;
	localparam logic [5:0] STATE_ADR = 6'h20;
	localparam logic [5:0] STICKY_ADR = 6'h21;

	// ***************************************************
	// fields
	// ***************************************************
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_MASK  = 8'h0e;
	localparam logic [7:0] IEN_RESET  = 8'h00;
	localparam logic [7:0] IEN_MASK   = 8'h23;
	localparam logic [7:0] STICKY_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE  = 8'h00;
	localparam int GND_BIT    = 1;
	localparam int TXD_BIT    = 2;
	localparam int RXD_BIT    = 3;
	localparam int RISE_BIT   = 0;
	localparam int FALL_BIT   = 1;
	localparam int RDONE_BIT  = 5;
	localparam int ST_FLOAT   = 0;
	localparam int ST_CODE_LO = 3;
	localparam int ST_DONE    = 6;
	localparam int LT_FLOAT   = 0;
	localparam int LT_RDONE   = 3;
	localparam logic [2:0] CODE_RESET = 3'h0;

	// ***************************************************
	// timing
	// ***************************************************
	localparam int CLK_MHZ      = 125;
	localparam int CONV_TIME_US = 282;
	localparam int CONV_CYCLES  = CONV_TIME_US * CLK_MHZ;
	localparam int CNT_W        = 16;

	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_SET   = 2'b01,
		OP_CLEAR = 2'b10,
		OP_NONE  = 2'b11
	} wr_op_e;

endpackage

/* common/conv_if.sv */
`timescale 1ns/1ps
interface conv_if;
	logic start;
	logic busy;
	logic done;
	modport ctl (output start, input busy, input done);
	modport tmr (input start, output busy, output done);
endinterface

/* core/conv_timer.sv */
`timescale 1ns/1ps
module conv_timer #(
	parameter int CYCLES = carkit_pkg::CONV_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	conv_if.tmr       cv
);

	typedef enum logic [0:0] {
		T_IDLE = 1'b0,
		T_RUN  = 1'b1
	} tstate_e;

	localparam logic [carkit_pkg::CNT_W-1:0] LAST =
		carkit_pkg::CNT_W'(CYCLES - 1);
	localparam logic [carkit_pkg::CNT_W-1:0] CNT_ZERO = 16'h0000;

	tstate_e                        st_q;
	logic [carkit_pkg::CNT_W-1:0]   cnt_q;
	logic                           done_q;

	// ***************************************************
	// conversion timing
	// ***************************************************
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q   <= T_IDLE;
			cnt_q  <= CNT_ZERO;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				T_IDLE: begin
					cnt_q <= CNT_ZERO;
					if (cv.start) begin
						st_q <= T_RUN;
					end
				end
				T_RUN: begin
					if (cnt_q == LAST) begin
						st_q   <= T_IDLE;
						done_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				default: st_q <= T_IDLE;
			endcase
		end
	end

	assign cv.busy = (st_q == T_RUN);
	assign cv.done = done_q;

endmodule

/* core/carkit_uart_id_regs.sv */
`timescale 1ns/1ps
module carkit_uart_id_regs #(
	parameter int CONV_CYCLES = carkit_pkg::CONV_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [5:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       accessory_uart_mode_i,
	input  wire logic       id_pin_pullup_i,
	input  wire logic       vendor_irq_en_i,
	input  wire logic       vendor_result_read_i,
	input  wire logic       conv_go_set_i,
	input  wire logic       conv_go_clr_i,
	input  wire logic       id_float_pin_i,
	input  wire logic [2:0] id_code_pin_i,
	input  wire logic       dp_pin_i,
	input  wire logic       data0_pin_i,
	input  wire logic       rxcmd_sent_i,
	output logic            id_pin_ground_drive_o,
	output logic            dm_pin_o,
	output logic            dm_pin_oe_o,
	output logic            data1_pin_o,
	output logic            data1_pin_oe_o,
	output logic            alt_int_o,
	output logic            resistor_conv_go_o,
	output logic            resistor_conv_done_o,
	output logic      [2:0] id_resistor_code_o
);

	// ***************************************************
	// pin synchronisers
	// ***************************************************
	localparam int SW = 6;
	localparam logic [SW-1:0] SYNC_ZERO = 6'h00;

	logic [SW-1:0] meta_q;
	logic [SW-1:0] sync_q;
	logic          id_float_raw;
	logic          dp_s;
	logic          txd_s;
	logic [2:0]    code_s;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_q <= SYNC_ZERO;
			sync_q <= SYNC_ZERO;
		end else begin
			meta_q <= {id_code_pin_i, data0_pin_i, dp_pin_i,
				id_float_pin_i};
			sync_q <= meta_q;
		end
	end

	assign id_float_raw = sync_q[0];
	assign dp_s         = sync_q[1];
	assign txd_s        = sync_q[2];
	assign code_s       = sync_q[5:3];

	// ***************************************************
	// write decode
	// ***************************************************
	carkit_pkg::wr_op_e ctrl_op;
	carkit_pkg::wr_op_e ien_op;

	function automatic logic [7:0] apply(
		input logic [7:0]         cur,
		input carkit_pkg::wr_op_e op,
		input logic [7:0]         wd,
		input logic [7:0]         msk
	);
		logic [7:0] r;
		r = cur;
		case (op)
			carkit_pkg::OP_WRITE: r = wd;
			carkit_pkg::OP_SET:   r = cur | wd;
			carkit_pkg::OP_CLEAR: r = cur & ~wd;
			default:              r = cur;
		endcase
		return r & msk;
	endfunction

	always_comb begin
		ctrl_op = carkit_pkg::OP_NONE;
		ien_op  = carkit_pkg::OP_NONE;
		if (reg_wr_i) begin
			case (reg_addr_i)
				carkit_pkg::CTRL_WR:  ctrl_op = carkit_pkg::OP_WRITE;
				carkit_pkg::CTRL_SET: ctrl_op = carkit_pkg::OP_SET;
				carkit_pkg::CTRL_CLR: ctrl_op = carkit_pkg::OP_CLEAR;
				carkit_pkg::IEN_WR:   ien_op = carkit_pkg::OP_WRITE;
				carkit_pkg::IEN_SET:  ien_op = carkit_pkg::OP_SET;
				carkit_pkg::IEN_CLR:  ien_op = carkit_pkg::OP_CLEAR;
				default: begin
					ctrl_op = carkit_pkg::OP_NONE;
					ien_op  = carkit_pkg::OP_NONE;
				end
			endcase
		end
	end

	// ***************************************************
	// control and enable registers
	// ***************************************************
	logic [7:0] ctrl_q;
	logic [7:0] ien_q;

	// masks keep the unimplemented bits at zero
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q <= carkit_pkg::CTRL_RESET;
		end else begin
			ctrl_q <= apply(ctrl_q, ctrl_op, reg_wdata_i,
				carkit_pkg::CTRL_MASK);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ien_q <= carkit_pkg::IEN_RESET;
		end else begin
			ien_q <= apply(ien_q, ien_op, reg_wdata_i,
				carkit_pkg::IEN_MASK);
		end
	end

	// ***************************************************
	// uart routing and id drive
	// ***************************************************
	logic uart_tx_route_en;
	logic uart_rx_route_en;

	assign uart_tx_route_en = ctrl_q[carkit_pkg::TXD_BIT];
	assign uart_rx_route_en = ctrl_q[carkit_pkg::RXD_BIT];

	// the link sets the route bits before accessory mode, so
	// enables are stable by the time mode gates the drivers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			id_pin_ground_drive_o <= 1'b0;
		end else begin
			id_pin_ground_drive_o <= ctrl_q[carkit_pkg::GND_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dm_pin_o    <= 1'b0;
			dm_pin_oe_o <= 1'b0;
		end else begin
			dm_pin_o    <= txd_s;
			dm_pin_oe_o <= accessory_uart_mode_i
				& uart_tx_route_en;
		end
	end

	// data line 1 idles high so the link never sees a false start bit
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			data1_pin_o    <= 1'b1;
			data1_pin_oe_o <= 1'b0;
		end else begin
			data1_pin_o <= uart_rx_route_en ? dp_s : 1'b1;
			data1_pin_oe_o <= accessory_uart_mode_i;
		end
	end

	// ***************************************************
	// id float detection
	// ***************************************************
	logic id_floating;
	logic id_float_prev_q;
	logic float_on_ev;
	logic float_off_ev;

	// without the pullup the pin level means nothing
	assign id_floating = id_float_raw & id_pin_pullup_i;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			id_float_prev_q <= 1'b0;
		end else begin
			id_float_prev_q <= id_floating;
		end
	end

	assign float_on_ev  = id_floating & ~id_float_prev_q
		& ien_q[carkit_pkg::RISE_BIT];
	assign float_off_ev = ~id_floating & id_float_prev_q
		& ien_q[carkit_pkg::FALL_BIT];

	// ***************************************************
	// resistor conversion
	// ***************************************************
	conv_if cv ();

	logic       go_q;
	logic       done_q;
	logic       done_prev_q;
	logic [2:0] code_q;
	logic       done_irq_en;
	logic       done_rise;

	conv_timer #(
		.CYCLES (CONV_CYCLES)
	) u_timer (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.cv     (cv)
	);

	// start only from idle; a set during a run is absorbed
	assign cv.start = go_q & ~cv.busy & ~cv.done;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			go_q <= 1'b0;
		end else if (cv.done) begin
			go_q <= 1'b0;
		end else if (conv_go_set_i) begin
			go_q <= 1'b1;
		end else if (conv_go_clr_i) begin
			go_q <= 1'b0;
		end
	end

	// set wins over the vendor read clear
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			done_q <= 1'b0;
		end else if (cv.done) begin
			done_q <= 1'b1;
		end else if (vendor_result_read_i) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			code_q <= carkit_pkg::CODE_RESET;
		end else if (cv.done) begin
			code_q <= code_s;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			done_prev_q <= 1'b0;
		end else begin
			done_prev_q <= done_q;
		end
	end

	assign done_irq_en = ien_q[carkit_pkg::RDONE_BIT]
		| vendor_irq_en_i;
	assign done_rise = done_q & ~done_prev_q & done_irq_en;

	assign resistor_conv_go_o   = go_q;
	assign resistor_conv_done_o = done_q;
	assign id_resistor_code_o   = code_q;

	// ***************************************************
	// status and latch
	// ***************************************************
	logic [7:0] state_v;
	logic [7:0] sticky_q;
	logic [7:0] sticky_set;
	logic       sticky_rd;

	always_comb begin
		state_v = carkit_pkg::ZERO_BYTE;
		state_v[carkit_pkg::ST_FLOAT] = id_floating;
		state_v[carkit_pkg::ST_CODE_LO +: 3] = code_q;
		state_v[carkit_pkg::ST_DONE] = done_q;
	end

	always_comb begin
		sticky_set = carkit_pkg::ZERO_BYTE;
		sticky_set[carkit_pkg::LT_FLOAT] =
			float_on_ev | float_off_ev;
		sticky_set[carkit_pkg::LT_RDONE] = done_rise;
	end

	assign sticky_rd = reg_rd_i
		& (reg_addr_i == carkit_pkg::STICKY_ADR);

	// an event in the read cycle survives the clear
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sticky_q <= carkit_pkg::STICKY_RESET;
		end else if (sticky_rd) begin
			sticky_q <= sticky_set;
		end else begin
			sticky_q <= sticky_q | sticky_set;
		end
	end

	// ***************************************************
	// alternate interrupt toward rxcmd
	// ***************************************************
	logic new_sticky;

	assign new_sticky = |(sticky_set & ~sticky_q);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			alt_int_o <= 1'b0;
		end else if (new_sticky) begin
			alt_int_o <= 1'b1;
		end else if (rxcmd_sent_i) begin
			alt_int_o <= 1'b0;
		end
	end

	// ***************************************************
	// read data
	// ***************************************************
	logic [7:0] rdata_d;

	always_comb begin
		case (reg_addr_i)
			carkit_pkg::CTRL_WR,
			carkit_pkg::CTRL_SET,
			carkit_pkg::CTRL_CLR:   rdata_d = ctrl_q;
			carkit_pkg::IEN_WR,
			carkit_pkg::IEN_SET,
			carkit_pkg::IEN_CLR:    rdata_d = ien_q;
			carkit_pkg::STATE_ADR:  rdata_d = state_v;
			carkit_pkg::STICKY_ADR: rdata_d = sticky_q;
			default:                rdata_d = carkit_pkg::ZERO_BYTE;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= carkit_pkg::ZERO_BYTE;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_d;
		end
	end

endmodule

/* verif/carkit_uart_id_regs_props.sv */
`timescale 1ns/1ps
module carkit_props #(
	parameter int CONV_CYCLES = 10
) (
	input wire logic       clk_i,
	input wire logic       nrst_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [5:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       accessory_uart_mode_i,
	input wire logic       vendor_result_read_i,
	input wire logic       rxcmd_sent_i,
	input wire logic       id_pin_ground_drive_o,
	input wire logic       dm_pin_oe_o,
	input wire logic       data1_pin_o,
	input wire logic       alt_int_o,
	input wire logic       resistor_conv_go_o,
	input wire logic       resistor_conv_done_o
);
	// ***************************************************
	// helpers
	// ***************************************************
	// counts go-high cycles; a repetition would be too long to unroll
	logic [15:0] go_cnt_q;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			go_cnt_q <= 16'h0000;
		end else begin
			go_cnt_q <= resistor_conv_go_o ? go_cnt_q + 16'h0001 : 16'h0000;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence quiet3;
		!reg_wr_i [*3];
	endsequence
	sequence conv_end;
		$fell(resistor_conv_go_o);
	endsequence
	property p_gnd;
		(reg_wr_i && reg_addr_i == 6'h19) ##1 quiet3
			|-> id_pin_ground_drive_o == $past(reg_wdata_i[1], 3);
	endproperty

	// ***************************************************
	// assertions
	// ***************************************************
	a_gnd_follows_ctrl: assert property (p_gnd)
		else $error("ground drive differs from written control bit");
	a_rx_off_high: assert property (
		(reg_wr_i && reg_addr_i == 6'h19 && !reg_wdata_i[3]) ##1 quiet3
		|-> data1_pin_o) else $error("data line 1 not high with rx off");
	a_dm_oe_mode: assert property (
		!accessory_uart_mode_i |=> !dm_pin_oe_o)
		else $error("dm driven outside accessory mode");
	a_alt_int_hold: assert property (
		alt_int_o && !rxcmd_sent_i |=> alt_int_o)
		else $error("alt_int dropped before rxcmd sent");
	a_conv_length: assert property (
		conv_end |-> resistor_conv_done_o
		&& go_cnt_q == 16'(CONV_CYCLES + 2))
		else $error("conversion length or done flag wrong");
	a_done_holds: assert property (
		resistor_conv_done_o && !vendor_result_read_i |=> resistor_conv_done_o)
		else $error("done flag cleared without vendor read");
	a_done_clears: assert property (
		resistor_conv_done_o && vendor_result_read_i && !resistor_conv_go_o
		|=> !resistor_conv_done_o) else $error("done flag not cleared");
	a_rdata_holds: assert property (
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");
	a_ctrl_reserved: assert property (
		reg_rd_i && reg_addr_i inside {6'h19, 6'h1a, 6'h1b}
		|=> (reg_rdata_o & 8'hf1) == 8'h00)
		else $error("control reserved bits not zero");
	a_state_reserved: assert property (
		reg_rd_i && reg_addr_i == 6'h20 |=> (reg_rdata_o & 8'h86) == 8'h00)
		else $error("status reserved bits not zero");
endmodule

bind carkit_uart_id_regs carkit_props #(.CONV_CYCLES(CONV_CYCLES)) props_u (
	.clk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
	.reg_rdata_o, .accessory_uart_mode_i, .vendor_result_read_i,
	.rxcmd_sent_i, .id_pin_ground_drive_o, .dm_pin_oe_o, .data1_pin_o,
	.alt_int_o, .resistor_conv_go_o, .resistor_conv_done_o);

/* verif/link_model.sv */
`timescale 1ns/1ps
module link_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [5:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            rxcmd_sent_o,
	output logic            uart_mode_o,
	output logic            pullup_o
);
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 6'h00;
		reg_wdata_o = 8'h00;
		rxcmd_sent_o = 1'b0;
		uart_mode_o = 1'b0;
		pullup_o = 1'b0;
	end
	// released lines show the inverse so stale values never match the ones last driven
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_o <= 1'b1;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		@(posedge clk_i);
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_rd_o <= 1'b1;
		reg_addr_o <= a;
		@(posedge clk_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		#1 d = reg_rdata_i;
	endtask
	// routing is settled before the accessory mode goes up
	task automatic enter_uart(input logic [7:0] ctrl);
		wr(6'h19, ctrl);
		@(posedge clk_i);
		uart_mode_o <= 1'b1;
	endtask
	task automatic set_pullup(input logic on);
		@(posedge clk_i);
		pullup_o <= on;
	endtask
	task automatic rxcmd();
		@(posedge clk_i);
		rxcmd_sent_o <= 1'b1;
		@(posedge clk_i);
		rxcmd_sent_o <= 1'b0;
		#1;
	endtask
endmodule

/* verif/test_carkit_uart_id_regs.sv */
`timescale 1ns/1ps
module test_carkit_uart_id_regs;
	localparam int CONV = 10;
	logic       clk_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic       reg_wr_i, reg_rd_i, accessory_uart_mode_i, id_pin_pullup_i;
	logic       rxcmd_sent_i, id_pin_ground_drive_o, dm_pin_o, dm_pin_oe_o;
	logic       data1_pin_o, data1_pin_oe_o, alt_int_o;
	logic       resistor_conv_go_o, resistor_conv_done_o;
	logic [5:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, rd_val;
	logic [2:0] id_resistor_code_o;
	logic [2:0] id_code_pin_i = 3'h0;
	logic       vendor_irq_en_i = 1'b0;
	logic       vendor_result_read_i = 1'b0;
	logic       conv_go_set_i = 1'b0;
	logic       conv_go_clr_i = 1'b0;
	logic       id_float_pin_i = 1'b0;
	logic       dp_pin_i = 1'b1;
	logic       data0_pin_i = 1'b1;
	int         mismatches = 0;
	int         samples_checked = 0;

	always #4 clk_i = ~clk_i;

	carkit_uart_id_regs #(.CONV_CYCLES(CONV)) dut (
		.clk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .accessory_uart_mode_i, .id_pin_pullup_i,
		.vendor_irq_en_i, .vendor_result_read_i, .conv_go_set_i,
		.conv_go_clr_i, .id_float_pin_i, .id_code_pin_i, .dp_pin_i,
		.data0_pin_i, .rxcmd_sent_i, .id_pin_ground_drive_o, .dm_pin_o,
		.dm_pin_oe_o, .data1_pin_o, .data1_pin_oe_o, .alt_int_o,
		.resistor_conv_go_o, .resistor_conv_done_o, .id_resistor_code_o);

	link_model link (
		.clk_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i), .rxcmd_sent_o(rxcmd_sent_i),
		.uart_mode_o(accessory_uart_mode_i), .pullup_o(id_pin_pullup_i));

	// ***************************************************
	// checking
	// ***************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bit_chk(input logic seen, input logic exp);
		check({7'h00, seen}, {7'h00, exp});
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
		link.rd(a, rd_val);
		check(rd_val, exp);
	endtask
	// synchroniser plus edge stage need three cycles; five leaves margin
	task automatic settle();
		repeat (5) @(posedge clk_i);
		#1;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ***************************************************
	// scenarios
	// ***************************************************
	task automatic t_regs();
		rd_chk(6'h19, 8'h00);
		rd_chk(6'h20, 8'h00);
		rd_chk(6'h21, 8'h00);
		link.wr(6'h19, 8'hff);
		rd_chk(6'h1a, 8'h0e);
		link.wr(6'h1b, 8'h04);
		rd_chk(6'h1b, 8'h0a);
		link.wr(6'h1a, 8'h01);
		rd_chk(6'h19, 8'h0a);
		bit_chk(id_pin_ground_drive_o, 1'b1);
		link.wr(6'h1d, 8'hff);
		rd_chk(6'h1e, 8'h23);
		link.wr(6'h1f, 8'h22);
		rd_chk(6'h1d, 8'h01);
		link.wr(6'h1e, 8'h20);
		rd_chk(6'h1f, 8'h21);
		link.wr(6'h20, 8'hff);
		rd_chk(6'h20, 8'h00);
		link.wr(6'h22, 8'hff);
		rd_chk(6'h22, 8'h00);
		link.wr(6'h1d, 8'h00);
		link.wr(6'h19, 8'h00);
		settle();
		bit_chk(id_pin_ground_drive_o, 1'b0);
		bit_chk(data1_pin_o, 1'b1);
		bit_chk(data1_pin_oe_o, 1'b0);
		$display("test regs done");
	endtask

	task automatic t_uart();
		link.enter_uart(8'h0c);
		@(posedge clk_i);
		data0_pin_i <= 1'b0;
		dp_pin_i <= 1'b0;
		settle();
		bit_chk(dm_pin_oe_o, 1'b1);
		bit_chk(data1_pin_oe_o, 1'b1);
		bit_chk(dm_pin_o, 1'b0);
		bit_chk(data1_pin_o, 1'b0);
		@(posedge clk_i);
		data0_pin_i <= 1'b1;
		settle();
		bit_chk(dm_pin_o, 1'b1);
		link.wr(6'h1b, 8'h08);
		settle();
		bit_chk(data1_pin_o, 1'b1);
		$display("test uart done");
	endtask

	task automatic t_float();
		link.set_pullup(1'b1);
		link.wr(6'h1d, 8'h01);
		@(posedge clk_i);
		id_float_pin_i <= 1'b1;
		settle();
		bit_chk(alt_int_o, 1'b1);
		rd_chk(6'h20, 8'h01);
		rd_chk(6'h21, 8'h01);
		rd_chk(6'h21, 8'h00);
		link.rxcmd();
		bit_chk(alt_int_o, 1'b0);
		link.wr(6'h1d, 8'h02);
		@(posedge clk_i);
		id_float_pin_i <= 1'b0;
		settle();
		bit_chk(alt_int_o, 1'b1);
		rd_chk(6'h21, 8'h01);
		link.rxcmd();
		link.wr(6'h1d, 8'h03);
		link.set_pullup(1'b0);
		@(posedge clk_i);
		id_float_pin_i <= 1'b1;
		settle();
		rd_chk(6'h20, 8'h00);
		bit_chk(alt_int_o, 1'b0);
		$display("test float done");
	endtask

	task automatic run_conv(input logic [2:0] code);
		int n;
		@(posedge clk_i);
		id_code_pin_i <= code;
		conv_go_set_i <= 1'b1;
		@(posedge clk_i);
		conv_go_set_i <= 1'b0;
		n = 0;
		while (resistor_conv_done_o !== 1'b1 && n < 4 * CONV) begin
			@(posedge clk_i);
			#1 n++;
		end
		bit_chk(resistor_conv_done_o, 1'b1);
		bit_chk(resistor_conv_go_o, 1'b0);
		settle();
	endtask

	task automatic t_conv();
		link.wr(6'h1d, 8'h20);
		run_conv(3'h3);
		rd_chk(6'h20, 8'h58);
		check({5'h00, id_resistor_code_o}, 8'h03);
		rd_chk(6'h20, 8'h58);
		bit_chk(alt_int_o, 1'b1);
		rd_chk(6'h21, 8'h08);
		link.rxcmd();
		@(posedge clk_i);
		vendor_result_read_i <= 1'b1;
		vendor_irq_en_i <= 1'b1;
		@(posedge clk_i);
		vendor_result_read_i <= 1'b0;
		link.wr(6'h1d, 8'h00);
		bit_chk(resistor_conv_done_o, 1'b0);
		run_conv(3'h7);
		bit_chk(alt_int_o, 1'b1);
		rd_chk(6'h21, 8'h08);
		rd_chk(6'h20, 8'h78);
		check({5'h00, id_resistor_code_o}, 8'h07);
		$display("test conv done");
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_regs();
		t_uart();
		t_float();
		t_conv();
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		stop_test();
	end
endmodule
